// ---- dv/tac_core_sva.sv ----
// Purpose: Port-level checks of the transfer activation control block.
// Assumes: One clock domain, reset active low.
// Notes: Bound to tac_core from the bench top.
`timescale 1ns/10ps
module tac_core_sva #(
	parameter int N_SRC = 8,
	parameter int VEC_W = 8,
	parameter logic [31:0] VEC_TABLE_BASE = 32'h0000_0400
) (
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic [N_SRC-1:0] src_req_i,
	input wire logic [N_SRC-1:0] src_clr_o,
	input wire logic [N_SRC-1:0] cpu_irq_o,
	input wire logic soft_end_irq_o,
	input wire logic mem_req_o,
	input wire logic mem_we_o,
	input wire logic [1:0] mem_size_o,
	input wire logic [31:0] mem_addr_o,
	input wire logic [31:0] mem_wdata_o,
	input wire logic [31:0] mem_rdata_i,
	input wire logic busy_o,
	input wire logic standby_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);
	sequence s_start;
		$rose(busy_o);
	endsequence
	sequence s_vec_read;
		mem_req_o && !mem_we_o && mem_addr_o[31:10] == VEC_TABLE_BASE[31:10];
	endsequence
	AST_VEC_FETCH: assert property (s_start |-> ##[0:1] s_vec_read)
		else $error("first access is not a vector table read");
	AST_VEC_LONG: assert property (s_start
		|-> ##1 mem_size_o == 2'h2)
		else $error("vector table read is not a long access");
	AST_READ_GAP: assert property (mem_req_o && !mem_we_o |=> !mem_req_o)
		else $error("read request not followed by idle cycle");
	AST_CLR_IRQ_EXCL: assert property ((src_clr_o & cpu_irq_o) == '0)
		else $error("flag clear and forward in one cycle");
	AST_CLR_PULSE: assert property (|src_clr_o |=> src_clr_o == '0)
		else $error("flag clear longer than one cycle");
	AST_IRQ_AFTER_WORK: assert property (|cpu_irq_o |-> $past(busy_o, 2))
		else $error("forwarded interrupt without a transfer");
	AST_SOFT_END_WB: assert property (soft_end_irq_o
		|-> $past(mem_we_o, 2) && !busy_o)
		else $error("soft end interrupt not right after write back");
	AST_RESET_STBY: assert property (!$past(reset_n_i) |-> standby_o)
		else $error("not in standby after reset");
	AST_STBY_READ: assert property (standby_o && reg_rd_i
		&& reg_addr_i != 8'h0c |=> reg_rdata_o == '0)
		else $error("register read in standby not zero");
	AST_STBY_SET: assert property (reg_wr_i && reg_addr_i == 8'h0c
		&& reg_wdata_i[1:0] == 2'h3 |=> standby_o)
		else $error("both stop bits did not enter standby");
endmodule

// ---- dv/tac_far_model.sv ----
// Purpose: On-chip RAM and peripheral request flags beside the block.
// Assumes: Reads answer in the cycle after the sampling edge.
// Notes: Idle read data toggles so stale values are never mistaken.
`timescale 1ns/10ps
module tac_far_model (
	input wire logic clk_i,
	input wire logic mem_req_i,
	input wire logic mem_we_i,
	input wire logic [31:0] mem_addr_i,
	input wire logic [31:0] mem_wdata_i,
	output logic [31:0] mem_rdata_o,
	input wire logic [7:0] src_clr_i,
	input wire logic [7:0] fire_i,
	output logic [7:0] src_req_o
);
	logic [31:0] mem [0:511];
	initial begin
		mem_rdata_o = 32'h0;
		src_req_o = 8'h0;
	end
	// Descriptors live here, so the RAM always answers.
	always @(posedge clk_i) begin
		if (mem_req_i && mem_we_i)
			mem[mem_addr_i[10:2]] <= mem_wdata_i;
		if (mem_req_i && !mem_we_i)
			mem_rdata_o <= mem[mem_addr_i[10:2]];
		else
			mem_rdata_o <= ~mem_rdata_o;
	end
	// A cleared flag drops one cycle after the pulse.
	always @(posedge clk_i)
		src_req_o <= (src_req_o & ~src_clr_i) | fire_i;
endmodule

// ---- dv/tb_top.sv ----
// Purpose: Directed bench for the transfer activation control block.
// Assumes: Descriptors preloaded into the model RAM at time zero.
// Notes: Pulse outputs are counted by a monitor, not sampled by tests.
`timescale 1ns/10ps
module tb_top;
	logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
	logic [7:0] addr = 8'h0, fire = 8'h0, req, clr, irq;
	logic [31:0] wdata = 32'h0, rdata, mrd, maddr, mwd;
	logic send, mreq, mwe, busy, stby;
	int mismatches = 0, checks = 0, cyc = 0, n_clr = 0, n_irq = 0, n_send = 0;
	always #5 clk = ~clk;
	tac_core u_dut (.core_clk_i(clk), .reset_n_i(rst_n), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
		.src_req_i(req), .src_clr_o(clr), .cpu_irq_o(irq),
		.soft_end_irq_o(send), .mem_req_o(mreq), .mem_we_o(mwe),
		.mem_size_o(), .mem_addr_o(maddr), .mem_wdata_o(mwd),
		.mem_rdata_i(mrd), .busy_o(busy), .standby_o(stby));
	tac_far_model u_far (.clk_i(clk), .mem_req_i(mreq), .mem_we_i(mwe),
		.mem_addr_i(maddr), .mem_wdata_i(mwd), .mem_rdata_o(mrd),
		.src_clr_i(clr), .fire_i(fire), .src_req_o(req));
	always @(posedge clk) begin
		n_clr += clr[0];
		n_irq += irq[0];
		n_send += send;
		cyc++;
		if (cyc == 3000) begin
			mismatches++;
			give_verdict();
		end
	end
	task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
		checks++;
		if (exp !== got) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wreg(logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(logic [7:0] a, logic [31:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk("rdata", exp, rdata);
	endtask
	task automatic wait_done();
		repeat (3) @(posedge clk);
		for (int i = 0; i < 150 && busy !== 1'b0; i++)
			@(posedge clk);
		repeat (3) @(posedge clk);
		chk("busy", 0, busy);
	endtask
	task automatic pulse_src();
		@(posedge clk);
		fire <= 8'h01;
		@(posedge clk);
		fire <= 8'h00;
		wait_done();
	endtask
	task give_verdict();
		if (mismatches == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		// Vector entries point at descriptors of three words each.
		u_far.mem[256] = 32'h100;
		u_far.mem[257] = 32'h120;
		u_far.mem[258] = 32'h130;
		u_far.mem[259] = 32'h140;
		u_far.mem['h40] = 32'h2000_0002;
		u_far.mem['h48] = 32'h0000_0003;
		u_far.mem['h4c] = 32'h0040_0005;
		u_far.mem['h50] = 32'h0080_0001;
		u_far.mem['h53] = 32'h0000_0001;
		// Sources and destinations stay in RAM, clear of the block.
		for (int i = 'h41; i < 'h53; i++)
			if (i % 4 != 0)
				u_far.mem[i] = (i % 4 == 1) ? 32'h200 : 32'h300;
		u_far.mem['h54] = 32'h200;
		u_far.mem['h55] = 32'h300;
		u_far.mem['h80] = 32'h5a;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1 chk("standby", 1, stby);
		rreg(8'h0c, 32'h3);
		wreg(8'h00, 32'h1);
		rreg(8'h00, 32'h0);
		wreg(8'h0c, 32'h0);
		#1 chk("standby", 0, stby);
		wreg(8'h08, 32'h0);
		rreg(8'h14, 32'h0);
		wreg(8'h00, 32'h1);
		pulse_src();
		chk("clr", 1, n_clr + 2 * n_irq);
		rreg(8'h00, 32'h1);
		chk("data", 32'h5a, u_far.mem['hc0]);
		chk("wb0", 32'h2000_0001, u_far.mem['h40]);
		chk("wb1", 32'h200, u_far.mem['h41]);
		chk("wb2", 32'h301, u_far.mem['h42]);
		pulse_src();
		chk("irq", 3, n_clr + 2 * n_irq);
		rreg(8'h00, 32'h0);
		chk("req", 1, req[0]);
		rreg(8'h04, 32'h0);
		wreg(8'h04, 32'h101);
		wait_done();
		rreg(8'h04, 32'h1);
		chk("soft wb", 32'h2, u_far.mem['h48]);
		wreg(8'h04, 32'h102);
		rreg(8'h04, 32'h102);
		wait_done();
		rreg(8'h04, 32'h102);
		chk("soft end", 1, n_send);
		wreg(8'h04, 32'h0);
		rreg(8'h04, 32'h0);
		wreg(8'h04, 32'h103);
		wait_done();
		chk("chain wb0", 32'h0080_0000, u_far.mem['h50]);
		chk("chain wb1", 32'h0, u_far.mem['h53]);
		chk("chain end", 2, n_send);
		wreg(8'h0c, 32'h3);
		#1 chk("standby", 1, stby);
		rreg(8'h04, 32'h0);
		give_verdict();
	end
endmodule
bind tac_core tac_core_sva #(.N_SRC(N_SRC), .VEC_W(VEC_W),
	.VEC_TABLE_BASE(VEC_TABLE_BASE)) u_sva (.*);

// ---- logic/tac_core.sv ----
// Purpose: Activation, descriptor fetch, transfer and completion control.
// Assumes: Memory answers a read in the cycle after it samples the request.
// Notes: Standby freezes the engine in place, standing in for a stopped clock.
`timescale 1ns/10ps
`include "tac_params.svh"

module tac_core #(
	parameter int N_SRC = 8,
	parameter int VEC_W = 8,
	parameter logic [31:0] VEC_TABLE_BASE = `TAC_VEC_TABLE
) (
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	input wire logic [N_SRC-1:0] src_req_i,
	output logic [N_SRC-1:0] src_clr_o,
	output logic [N_SRC-1:0] cpu_irq_o,
	output logic soft_end_irq_o,
	output logic mem_req_o,
	output logic mem_we_o,
	output logic [1:0] mem_size_o,
	output logic [31:0] mem_addr_o,
	output logic [31:0] mem_wdata_o,
	input wire logic [31:0] mem_rdata_i,
	output logic busy_o,
	output logic standby_o
);

	localparam int SRC_W = (N_SRC > 1) ? $clog2(N_SRC) : 1;
	tac_pkg::tac_state_e state_r;
	logic [1:0] ph_r, idx_r, stop_r;
	logic act_soft_r, soft_flag_r, soft_armed_r, standby_r, busy_r;
	logic [VEC_W-1:0] act_vec_r, soft_vec_r;
	logic [15:0] d_mode_r, d_cnt_r, base_r;
	tac_pkg::tac_word_t d_ptr_r, d_src_r, d_dst_r, data_r;
	logic [N_SRC-1:0] act_en_r;

	logic pend_any, start_irq, start_soft, irq_due, chain, fin_last;
	logic is_rd, is_wr, acc_ok, wr_en, rd_en;
	logic [SRC_W-1:0] pend_idx;
	logic [15:0] cnt_nxt;
	logic [N_SRC-1:0] act_onehot;
	tac_pkg::tac_word_t acc_addr, acc_wdata, src_nxt, dst_nxt;

	tac_src_pick #(
		.N_SRC(N_SRC),
		.SRC_W(SRC_W)
	) u_pick (
		.pend_i(src_req_i & act_en_r),
		.any_o(pend_any),
		.idx_o(pend_idx)
	);

	function automatic tac_pkg::tac_word_t step_addr(
		input tac_pkg::tac_word_t a,
		input logic [1:0] step,
		input logic [1:0] size
	);
		tac_pkg::tac_word_t unit;
		unit = (size == `TAC_SZ_LONG) ? 32'h0000_0004 :
			(size == `TAC_SZ_WORD) ? 32'h0000_0002 : 32'h0000_0001;
		case (step)
			`TAC_STEP_INC: step_addr = a + unit;
			`TAC_STEP_DEC: step_addr = a - unit;
			default: step_addr = a;
		endcase
	endfunction

	// The clear pulse of the last completion is still in flight while the
	// peripheral flag is high, so a new source start waits for it to land; a soft start does not.
	always_comb begin
		start_irq = (state_r == tac_pkg::TAC_IDLE) && !standby_r &&
			pend_any && (src_clr_o == '0);
		start_soft = (state_r == tac_pkg::TAC_IDLE) && !standby_r &&
			!start_irq && soft_armed_r;
		cnt_nxt = d_cnt_r - 16'h0001;
		chain = d_mode_r[`TAC_M_CHAIN];
		irq_due = d_mode_r[`TAC_M_IRQSEL] || (cnt_nxt == 16'h0000);
		fin_last = (state_r == tac_pkg::TAC_FIN) && !standby_r && !chain;
		is_rd = (state_r == tac_pkg::TAC_VEC) ||
			(state_r == tac_pkg::TAC_DESC) || (state_r == tac_pkg::TAC_DRD);
		is_wr = (state_r == tac_pkg::TAC_DWR) || (state_r == tac_pkg::TAC_WB);
		src_nxt = step_addr(d_src_r, d_mode_r[`TAC_M_SSTEP +: 2],
			d_mode_r[`TAC_M_SIZE +: 2]);
		dst_nxt = step_addr(d_dst_r, d_mode_r[`TAC_M_DSTEP +: 2],
			d_mode_r[`TAC_M_SIZE +: 2]);
		act_onehot = '0;
		act_onehot[act_vec_r[SRC_W-1:0]] = 1'b1;
		acc_addr = d_ptr_r + {28'h0, idx_r, 2'h0};
		acc_wdata = data_r;
		case (state_r)
			tac_pkg::TAC_VEC:
				acc_addr = VEC_TABLE_BASE +
					{{(30 - VEC_W){1'b0}}, act_vec_r, 2'h0};
			tac_pkg::TAC_DRD: acc_addr = d_src_r;
			tac_pkg::TAC_DWR: acc_addr = d_dst_r;
			tac_pkg::TAC_WB: begin
				if (idx_r == 2'h0) begin
					acc_wdata = {d_mode_r, cnt_nxt};
				end else if (idx_r == 2'h1) begin
					acc_wdata = src_nxt;
				end else begin
					acc_wdata = dst_nxt;
				end
			end
			default: ;
		endcase
	end

	// Engine: each read takes issue, wait and capture; a write takes two.
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_r <= tac_pkg::TAC_IDLE;
			ph_r <= 2'h0;
			idx_r <= 2'h0;
			act_soft_r <= 1'b0;
			act_vec_r <= '0;
			d_ptr_r <= 32'h0000_0000;
			d_mode_r <= 16'h0000;
			d_cnt_r <= 16'h0000;
			d_src_r <= 32'h0000_0000;
			d_dst_r <= 32'h0000_0000;
			data_r <= 32'h0000_0000;
			mem_req_o <= 1'b0;
			mem_we_o <= 1'b0;
			mem_size_o <= 2'h0;
			mem_addr_o <= 32'h0000_0000;
			mem_wdata_o <= 32'h0000_0000;
			busy_r <= 1'b0;
		end else if (!standby_r) begin
			if (start_irq) begin
				act_soft_r <= 1'b0;
				act_vec_r <= VEC_W'(pend_idx);
				state_r <= tac_pkg::TAC_VEC;
				busy_r <= 1'b1;
			end else if (start_soft) begin
				act_soft_r <= 1'b1;
				act_vec_r <= soft_vec_r;
				state_r <= tac_pkg::TAC_VEC;
				busy_r <= 1'b1;
			end
			if (is_rd || is_wr) begin
				if (ph_r == 2'h0) begin
					mem_req_o <= 1'b1;
					mem_we_o <= is_wr;
					mem_size_o <= is_wr || state_r == tac_pkg::TAC_DRD ?
						((state_r == tac_pkg::TAC_WB) ? `TAC_SZ_LONG :
						d_mode_r[`TAC_M_SIZE +: 2]) : `TAC_SZ_LONG;
					mem_addr_o <= acc_addr;
					mem_wdata_o <= acc_wdata;
					ph_r <= 2'h1;
				end else if (ph_r == 2'h1 && is_rd) begin
					mem_req_o <= 1'b0;
					ph_r <= 2'h2;
				end else begin
					mem_req_o <= 1'b0;
					mem_we_o <= 1'b0;
					ph_r <= 2'h0;
					case (state_r)
						tac_pkg::TAC_VEC: begin
							d_ptr_r <= {base_r, mem_rdata_i[15:0]};
							idx_r <= 2'h0;
							state_r <= tac_pkg::TAC_DESC;
						end
						tac_pkg::TAC_DESC: begin
							idx_r <= idx_r + 2'h1;
							if (idx_r == 2'h0) begin
								d_mode_r <= mem_rdata_i[31:16];
								d_cnt_r <= mem_rdata_i[15:0];
							end else if (idx_r == 2'h1) begin
								d_src_r <= mem_rdata_i;
							end else begin
								d_dst_r <= mem_rdata_i;
								state_r <= tac_pkg::TAC_DRD;
							end
						end
						tac_pkg::TAC_DRD: begin
							data_r <= mem_rdata_i;
							state_r <= tac_pkg::TAC_DWR;
						end
						tac_pkg::TAC_DWR: begin
							idx_r <= 2'h0;
							state_r <= tac_pkg::TAC_WB;
						end
						default: begin
							idx_r <= idx_r + 2'h1;
							if (idx_r == 2'h2) begin
								state_r <= tac_pkg::TAC_FIN;
							end
						end
					endcase
				end
			end
			if (state_r == tac_pkg::TAC_FIN) begin
				idx_r <= 2'h0;
				if (chain) begin
					d_ptr_r <= d_ptr_r + `TAC_DESC_STRIDE;
					state_r <= tac_pkg::TAC_DESC;
				end else begin
					state_r <= tac_pkg::TAC_IDLE;
					busy_r <= 1'b0;
				end
			end
		end
	end

	// Completion pulses toward peripherals and the CPU interrupt controller.
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			src_clr_o <= '0;
			cpu_irq_o <= '0;
			soft_end_irq_o <= 1'b0;
		end else begin
			src_clr_o <= '0;
			cpu_irq_o <= '0;
			soft_end_irq_o <= 1'b0;
			if (fin_last && !act_soft_r) begin
				if (irq_due) begin
					cpu_irq_o <= act_onehot;
				end else begin
					src_clr_o <= act_onehot;
				end
			end
			if (fin_last && act_soft_r && irq_due) begin
				soft_end_irq_o <= 1'b1;
			end
		end
	end

	assign acc_ok = !standby_r || (reg_addr_i == `TAC_OFS_STBY);
	assign wr_en = reg_wr_i && acc_ok;
	assign rd_en = reg_rd_i && acc_ok;

	// A software write wins over a hardware clear in the same cycle.
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			act_en_r <= N_SRC'(`TAC_ACT_EN_RST);
		end else if (wr_en && reg_addr_i == `TAC_OFS_ACT_EN) begin
			act_en_r <= reg_wdata_i[N_SRC-1:0];
		end else if (fin_last && !act_soft_r && irq_due) begin
			act_en_r <= act_en_r & ~act_onehot;
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			soft_flag_r <= 1'b0;
			soft_armed_r <= 1'b0;
			soft_vec_r <= '0;
		end else begin
			if (wr_en && reg_addr_i == `TAC_OFS_SOFT) begin
				soft_flag_r <= reg_wdata_i[`TAC_SOFT_FLAG_BIT];
				soft_armed_r <= reg_wdata_i[`TAC_SOFT_FLAG_BIT];
				soft_vec_r <= reg_wdata_i[VEC_W-1:0];
			end else begin
				if (start_soft) begin
					soft_armed_r <= 1'b0;
				end
				if (fin_last && act_soft_r && !irq_due) begin
					soft_flag_r <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			base_r <= 16'h0000;
		end else if (wr_en && reg_addr_i == `TAC_OFS_BASE) begin
			base_r <= reg_wdata_i[31:16];
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			stop_r <= `TAC_STBY_RST;
			standby_r <= 1'b1;
		end else if (reg_wr_i && reg_addr_i == `TAC_OFS_STBY) begin
			stop_r <= reg_wdata_i[1:0];
			standby_r <= reg_wdata_i[`TAC_STBY_A_BIT] &&
				reg_wdata_i[`TAC_STBY_B_BIT];
		end
	end

	// Read data stands for one cycle only; refused reads return zero.
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			reg_rdata_o <= 32'h0000_0000;
		end else begin
			reg_rdata_o <= 32'h0000_0000;
			if (rd_en) begin
				case (reg_addr_i)
					`TAC_OFS_ACT_EN: reg_rdata_o <= 32'(act_en_r);
					`TAC_OFS_SOFT: reg_rdata_o <= {23'h0, soft_flag_r,
						soft_vec_r};
					`TAC_OFS_BASE: reg_rdata_o <= {base_r, 16'h0000};
					`TAC_OFS_STBY: reg_rdata_o <= {30'h0, stop_r};
					`TAC_OFS_STAT: reg_rdata_o <= {16'h0, act_vec_r, 3'h0,
						state_r, standby_r, busy_r};
					default: reg_rdata_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign busy_o = busy_r;
	assign standby_o = standby_r;

endmodule

// ---- logic/tac_params.svh ----
// Purpose: Constants shared by the transfer activation control block.
// Assumes: Byte addresses on the register port, 32-bit data.
// Notes: Descriptor mode fields sit in the upper half of descriptor word 0.
`ifndef TAC_PARAMS_SVH
`define TAC_PARAMS_SVH

`define TAC_OFS_ACT_EN 8'h00
`define TAC_OFS_SOFT 8'h04
`define TAC_OFS_BASE 8'h08
`define TAC_OFS_STBY 8'h0c
`define TAC_OFS_STAT 8'h10

`define TAC_SOFT_FLAG_BIT 8
`define TAC_STBY_A_BIT 0
`define TAC_STBY_B_BIT 1
`define TAC_STBY_RST 2'h3
`define TAC_ACT_EN_RST 32'h0000_0000

`define TAC_VEC_TABLE 32'h0000_0400
`define TAC_DESC_STRIDE 32'h0000_000c

`define TAC_M_SSTEP 14
`define TAC_M_DSTEP 12
`define TAC_M_MODE 10
`define TAC_M_SIZE 8
`define TAC_M_CHAIN 7
`define TAC_M_IRQSEL 6

`define TAC_STEP_FIXED 2'h0
`define TAC_STEP_INC 2'h2
`define TAC_STEP_DEC 2'h3
`define TAC_SZ_BYTE 2'h0
`define TAC_SZ_WORD 2'h1
`define TAC_SZ_LONG 2'h2

`endif

// ---- logic/tac_pkg.sv ----
// Purpose: Types of the transfer activation control block.
// Assumes: Constants come from tac_params.svh.
// Notes: State codes follow a Gray sequence along the normal path.
package tac_pkg;

	typedef enum logic [2:0] {
		TAC_IDLE = 3'h0,
		TAC_VEC = 3'h1,
		TAC_DESC = 3'h3,
		TAC_DRD = 3'h2,
		TAC_DWR = 3'h6,
		TAC_WB = 3'h7,
		TAC_FIN = 3'h5
	} tac_state_e;

	typedef logic [31:0] tac_word_t;

endpackage

// ---- logic/tac_src_pick.sv ----
// Purpose: Picks the lowest numbered pending and enabled activation source.
// Assumes: Inputs come from logic on the same clock.
// Notes: Purely combinational; lower index has higher priority.
`timescale 1ns/10ps
module tac_src_pick #(
	parameter int N_SRC = 8,
	parameter int SRC_W = 3
) (
	input wire logic [N_SRC-1:0] pend_i,
	output logic any_o,
	output logic [SRC_W-1:0] idx_o
);

	always_comb begin
		any_o = 1'b0;
		idx_o = '0;
		for (int i = N_SRC - 1; i >= 0; i--) begin
			if (pend_i[i]) begin
				any_o = 1'b1;
				idx_o = SRC_W'(i);
			end
		end
	end

endmodule
